// >>> core/bleec_pkg.sv
/*
 * Package for the loader entry controller: state encoding, register map,
 * configuration field layout, timing constants and bundled signal types.
 * Assumes a single 125 MHz core clock and a plain strobe register port.
 */
package bleec_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 8000;
    localparam int unsigned PIN_SETTLE_NS = 1000;
    localparam int unsigned PIN_SETTLE_CYC = (PIN_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned SETTLE_W = 8;

    // ------------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CMD = 8'h08;
    localparam logic [7:0] REG_PWD = 8'h10;
    localparam logic [7:0] REG_PWD_LAST = 8'h2C;

    // cfg fields
    localparam int unsigned CFG_EN_BIT = 0;
    localparam int unsigned CFG_FAST_BIT = 1;
    localparam int unsigned CFG_LEVEL_BIT = 2;
    localparam logic [2:0] CFG_RESET = 3'h5;

    // cmd register: write code to request system reset into the loader
    localparam logic [31:0] CMD_LOADER_ENTRY = 32'h0000_0A5E;
    localparam logic [31:0] CMD_APP_RESET = 32'h0000_0A50;

    // password
    localparam int unsigned PWD_BITS = 256;
    localparam int unsigned PWD_WORDS = PWD_BITS / 32;
    localparam logic [PWD_BITS-1:0] PWD_DEFAULT = {PWD_WORDS{32'hFFFF_FFFF}};

    // blank flash word
    localparam logic [31:0] BLANK_WORD = 32'hFFFF_FFFF;

    // entry cause codes
    localparam logic [2:0] CAUSE_NONE = 3'h0;
    localparam logic [2:0] CAUSE_PIN = 3'h1;
    localparam logic [2:0] CAUSE_BLANK = 3'h2;
    localparam logic [2:0] CAUSE_SWREQ = 3'h3;
    localparam logic [2:0] CAUSE_DISABLED = 3'h4;

    typedef enum logic [4:0] {
        ST_RESET = 5'b00001,
        ST_SETTLE = 5'b00010,
        ST_CHECK = 5'b00100,
        ST_APP = 5'b01000,
        ST_LOADER = 5'b10000
    } bleec_state_t;

    typedef struct packed {
        logic en;
        logic fast_boot;
        logic entry_level;
    } bleec_cfg_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bleec_req_t;

endpackage

// >>> core/bleec_sync.sv
/*
 * Two-flop synchroniser for asynchronous pin levels.
 * Assumes the input is a slow level; the first stage feeds only the second.
 */
`timescale 1ns/1ps
module bleec_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic i_core_clk, // core clock
    input wire logic i_rst, // async reset, active high
    input wire logic i_async, // pin level
    output logic o_sync // synchronised level
);
    logic meta_q;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule

// >>> core/bleec_top.sv
/*
 * Loader entry controller: decides after each boot whether the serial boot
 * loader or the application starts, gates loader memory access behind a
 * 256-bit password, and routes the loader link pins.
 * Assumes a 125 MHz core clock, asynchronous active-high reset, vector and
 * stack words presented stable by the flash interface, and a strobe-based
 * register port with read data one cycle after the read strobe.
 */
`timescale 1ns/1ps

module bleec_top (
    input wire logic i_core_clk, // core clock, 125 MHz
    input wire logic i_rst, // async reset, active high
    input wire logic i_loader_entry_pin, // entry request pin
    input wire logic i_external_reset_pin_n, // reset pin, active low
    input wire logic [31:0] i_reset_vector, // flash word: reset vector
    input wire logic [31:0] i_stack_pointer, // flash word: initial stack
    input wire logic i_sel_i2c, // link select: 1 = i2c, 0 = uart
    input wire logic i_loader_uart_rx, // uart receive pin
    input wire logic i_loader_i2c_clock, // i2c clock pin level
    input wire logic i_loader_i2c_data, // i2c data pin level
    input wire logic i_link_tx, // loader serial out (uart)
    input wire logic i_link_sda_low, // loader pulls sda low
    input wire logic i_link_scl_low, // loader stretches scl
    input wire logic [7:0] i_addr, // register address
    input wire logic [31:0] i_wdata, // register write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    output logic [31:0] o_rdata, // read data, cycle after strobe
    output logic o_loader_run, // loader selected
    output logic o_app_run, // application selected
    output logic o_access_ok, // memory access unlocked
    output logic o_boot_reset, // one-cycle boot reset pulse
    output logic o_loader_uart_tx, // uart transmit pin
    output logic o_loader_i2c_clock_oe, // scl drive low enable
    output logic o_loader_i2c_data_oe, // sda drive low enable
    output logic o_loader_i2c_clock_o, // scl output value
    output logic o_loader_i2c_data_o, // sda output value
    output logic o_link_rx, // serial in to loader
    output logic o_link_scl, // scl level to loader
    output logic o_link_sda // sda level to loader
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic entry_pin_s;
    logic rst_pin_n_s;
    logic rx_s;
    logic scl_s;
    logic sda_s;

    bleec_sync #(.RST_VAL(1'b0)) u_sync_entry (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_async(i_loader_entry_pin),
        .o_sync(entry_pin_s)
    );
    bleec_sync #(.RST_VAL(1'b1)) u_sync_rst (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_async(i_external_reset_pin_n),
        .o_sync(rst_pin_n_s)
    );
    bleec_sync #(.RST_VAL(1'b1)) u_sync_rx (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_async(i_loader_uart_rx),
        .o_sync(rx_s)
    );
    bleec_sync #(.RST_VAL(1'b1)) u_sync_scl (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_async(i_loader_i2c_clock),
        .o_sync(scl_s)
    );
    bleec_sync #(.RST_VAL(1'b1)) u_sync_sda (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_async(i_loader_i2c_data),
        .o_sync(sda_s)
    );

    // ------------------------------------------------------------------
    // configuration and password store
    // ------------------------------------------------------------------
    bleec_pkg::bleec_req_t req;
    bleec_pkg::bleec_cfg_t cfg_q;
    bleec_pkg::bleec_state_t state_q;
    logic [31:0] pwd_q [bleec_pkg::PWD_WORDS];
    logic [31:0] try_q [bleec_pkg::PWD_WORDS];
    logic [bleec_pkg::PWD_WORDS-1:0] word_ok;
    logic unlocked_q;
    logic pwd_attempt_q;
    logic sw_req_q;
    logic sw_entry_q;
    logic rst_pin_d1_q;
    logic [2:0] cause_q;
    logic [bleec_pkg::SETTLE_W-1:0] settle_q;
    logic in_pwd;
    logic [2:0] widx;

    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
    assign in_pwd = (req.addr >= bleec_pkg::REG_PWD) && (req.addr <= bleec_pkg::REG_PWD_LAST)
                    && (req.addr[1:0] == 2'b00);
    assign widx = 3'((req.addr - bleec_pkg::REG_PWD) >> 2);

    // cfg writes only while the application runs or the loader is unlocked: the loader cannot rewrite
    // its own gate without the password
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cfg_q <= bleec_pkg::CFG_RESET;
        end else if (req.wr && req.addr == bleec_pkg::REG_CFG &&
                     (state_q == bleec_pkg::ST_APP || unlocked_q)) begin
            cfg_q.en <= req.wdata[bleec_pkg::CFG_EN_BIT];
            cfg_q.fast_boot <= req.wdata[bleec_pkg::CFG_FAST_BIT];
            cfg_q.entry_level <= req.wdata[bleec_pkg::CFG_LEVEL_BIT];
        end
    end

    // stored password is set by the application, tried by the loader host
    genvar gi;
    generate
        for (gi = 0; gi < bleec_pkg::PWD_WORDS; gi++) begin : g_pwd
            always_ff @(posedge i_core_clk or posedge i_rst) begin
                if (i_rst) begin
                    pwd_q[gi] <= bleec_pkg::PWD_DEFAULT[gi*32 +: 32];
                    try_q[gi] <= 32'h0000_0000;
                end else if (req.wr && in_pwd && widx == 3'(gi)) begin
                    if (state_q == bleec_pkg::ST_APP) begin
                        pwd_q[gi] <= req.wdata;
                    end else begin
                        try_q[gi] <= req.wdata;
                    end
                end
            end
            assign word_ok[gi] = (pwd_q[gi] == try_q[gi]);
        end
    endgenerate

    // attempt completes on the write of the last word
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pwd_attempt_q <= 1'b0;
        end else begin
            pwd_attempt_q <= req.wr && req.addr == bleec_pkg::REG_PWD_LAST &&
                             state_q == bleec_pkg::ST_LOADER;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            unlocked_q <= 1'b0;
        end else if (state_q != bleec_pkg::ST_LOADER) begin
            unlocked_q <= 1'b0;
        end else if (pwd_attempt_q) begin
            unlocked_q <= &word_ok;
        end
    end

    // ------------------------------------------------------------------
    // software reset request
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sw_req_q <= 1'b0;
            sw_entry_q <= 1'b0;
        end else if (req.wr && req.addr == bleec_pkg::REG_CMD &&
                     (req.wdata == bleec_pkg::CMD_LOADER_ENTRY ||
                      req.wdata == bleec_pkg::CMD_APP_RESET)) begin
            sw_req_q <= 1'b1;
            sw_entry_q <= (req.wdata == bleec_pkg::CMD_LOADER_ENTRY);
        end else if (state_q == bleec_pkg::ST_CHECK) begin
            sw_req_q <= 1'b0;
            sw_entry_q <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rst_pin_d1_q <= 1'b1;
        end else begin
            rst_pin_d1_q <= rst_pin_n_s;
        end
    end

    // ------------------------------------------------------------------
    // boot sequence
    // ------------------------------------------------------------------
    // the pin reset holds the sequence in ST_RESET; its release starts a
    // fresh boot, so the host's held entry level is seen again
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= bleec_pkg::ST_RESET;
            settle_q <= '0;
            cause_q <= bleec_pkg::CAUSE_NONE;
        end else if (!rst_pin_n_s) begin
            state_q <= bleec_pkg::ST_RESET;
            settle_q <= '0;
        end else begin
            unique case (state_q)
                bleec_pkg::ST_RESET: begin
                    state_q <= bleec_pkg::ST_SETTLE;
                    settle_q <= '0;
                end
                bleec_pkg::ST_SETTLE: begin
                    if (settle_q == bleec_pkg::SETTLE_W'(bleec_pkg::PIN_SETTLE_CYC - 1)) begin
                        state_q <= bleec_pkg::ST_CHECK;
                    end else begin
                        settle_q <= settle_q + 1'b1;
                    end
                end
                bleec_pkg::ST_CHECK: begin
                    if (!cfg_q.en) begin
                        state_q <= bleec_pkg::ST_APP;
                        cause_q <= bleec_pkg::CAUSE_DISABLED;
                    end else if (sw_entry_q) begin
                        state_q <= bleec_pkg::ST_LOADER;
                        cause_q <= bleec_pkg::CAUSE_SWREQ;
                    end else if (i_reset_vector == bleec_pkg::BLANK_WORD &&
                                 i_stack_pointer == bleec_pkg::BLANK_WORD) begin
                        state_q <= bleec_pkg::ST_LOADER;
                        cause_q <= bleec_pkg::CAUSE_BLANK;
                    end else if (!cfg_q.fast_boot && entry_pin_s == cfg_q.entry_level) begin
                        state_q <= bleec_pkg::ST_LOADER;
                        cause_q <= bleec_pkg::CAUSE_PIN;
                    end else begin
                        state_q <= bleec_pkg::ST_APP;
                        cause_q <= bleec_pkg::CAUSE_NONE;
                    end
                end
                bleec_pkg::ST_APP: begin
                    if (sw_req_q) begin
                        state_q <= bleec_pkg::ST_RESET;
                    end
                end
                bleec_pkg::ST_LOADER: begin
                    if (sw_req_q) begin
                        state_q <= bleec_pkg::ST_RESET;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_loader_run <= 1'b0;
            o_app_run <= 1'b0;
            o_access_ok <= 1'b0;
            o_boot_reset <= 1'b0;
        end else begin
            o_loader_run <= (state_q == bleec_pkg::ST_LOADER);
            o_app_run <= (state_q == bleec_pkg::ST_APP);
            o_access_ok <= unlocked_q && state_q == bleec_pkg::ST_LOADER;
            o_boot_reset <= rst_pin_d1_q && !rst_pin_n_s;
        end
    end

    // link routing: only the selected pair is active, others idle high
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_loader_uart_tx <= 1'b1;
            o_loader_i2c_clock_oe <= 1'b0;
            o_loader_i2c_data_oe <= 1'b0;
            o_loader_i2c_clock_o <= 1'b0;
            o_loader_i2c_data_o <= 1'b0;
            o_link_rx <= 1'b1;
            o_link_scl <= 1'b1;
            o_link_sda <= 1'b1;
        end else begin
            o_loader_uart_tx <= (state_q == bleec_pkg::ST_LOADER && !i_sel_i2c) ? i_link_tx : 1'b1;
            o_loader_i2c_clock_oe <= state_q == bleec_pkg::ST_LOADER && i_sel_i2c && i_link_scl_low;
            o_loader_i2c_data_oe <= state_q == bleec_pkg::ST_LOADER && i_sel_i2c && i_link_sda_low;
            o_loader_i2c_clock_o <= 1'b0;
            o_loader_i2c_data_o <= 1'b0;
            o_link_rx <= i_sel_i2c ? 1'b1 : rx_s;
            o_link_scl <= i_sel_i2c ? scl_s : 1'b1;
            o_link_sda <= i_sel_i2c ? sda_s : 1'b1;
        end
    end

    // password words never read back
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 32'h0000_0000;
        end else if (req.rd) begin
            unique case (req.addr)
                bleec_pkg::REG_CFG: o_rdata <= {29'h0, cfg_q.entry_level, cfg_q.fast_boot, cfg_q.en};
                bleec_pkg::REG_STATUS: o_rdata <= {22'h0, cause_q, entry_pin_s, unlocked_q, state_q};
                default: o_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

endmodule

// >>> tb/bleec_top_asserts.sv
/*
 * Checker for the loader entry controller, bound to bleec_top.
 * Assumes a single core clock domain with async active-high reset.
 */
`timescale 1ns/1ps
module bleec_chk (
    input wire logic i_core_clk, // core clock
    input wire logic i_rst, // reset
    input wire logic i_rd, // read strobe
    input wire logic [31:0] o_rdata, // read data
    input wire logic o_loader_run, // loader selected
    input wire logic o_app_run, // app selected
    input wire logic o_access_ok, // unlocked
    input wire logic o_boot_reset, // boot reset pulse
    input wire logic o_loader_uart_tx, // uart tx
    input wire logic o_loader_i2c_clock_o, // scl value
    input wire logic o_loader_i2c_data_o, // sda value
    input wire logic o_loader_i2c_data_oe, // sda enable
    input wire logic i_link_sda_low, // sda pull request
    input wire logic i_sel_i2c, // link select
    input wire logic i_external_reset_pin_n // reset pin
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // ------------------------------------------------------------------
    // boot reset steps
    // ------------------------------------------------------------------
    sequence s_pin_fall;
        $fell(i_external_reset_pin_n);
    endsequence
    sequence s_pulse_soon;
        ##[1:4] o_boot_reset;
    endsequence
    sequence s_runs_drop;
        ##[1:4] !(o_loader_run || o_app_run);
    endsequence
    chk_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data not zero outside answer cycle");
    chk_run_one_hot: assert property (!(o_loader_run && o_app_run))
        else $error("loader and application both selected");
    chk_pulse_one_cycle: assert property (o_boot_reset |=> !o_boot_reset)
        else $error("boot reset pulse longer than one cycle");
    chk_access_in_loader: assert property (o_access_ok |-> o_loader_run || $past(o_loader_run))
        else $error("access unlocked outside loader");
    chk_tx_idle_high: assert property (!o_loader_run && !$past(o_loader_run) |-> o_loader_uart_tx)
        else $error("uart tx driven outside loader");
    chk_i2c_out_low: assert property (!o_loader_i2c_clock_o && !o_loader_i2c_data_o)
        else $error("open drain output value not low");
    chk_sda_oe_cause: assert property (o_loader_i2c_data_oe |-> $past(i_link_sda_low) && $past(i_sel_i2c))
        else $error("sda driven without request");
    chk_pin_to_pulse: assert property (s_pin_fall |-> s_pulse_soon)
        else $error("no boot reset after reset pin fall");
    chk_pulse_stops_run: assert property (o_boot_reset |-> s_runs_drop)
        else $error("run not dropped after boot reset");
endmodule

bind bleec_top bleec_chk u_chk (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_loader_run(o_loader_run),
    .o_app_run(o_app_run),
    .o_access_ok(o_access_ok),
    .o_boot_reset(o_boot_reset),
    .o_loader_uart_tx(o_loader_uart_tx),
    .o_loader_i2c_clock_o(o_loader_i2c_clock_o),
    .o_loader_i2c_data_o(o_loader_i2c_data_o),
    .o_loader_i2c_data_oe(o_loader_i2c_data_oe),
    .i_link_sda_low(i_link_sda_low),
    .i_sel_i2c(i_sel_i2c),
    .i_external_reset_pin_n(i_external_reset_pin_n)
);

// >>> tb/bleec_host_model.sv
/*
 * External programming host: drives entry and reset pins and the link.
 * Assumes pulled-up open-drain i2c lines and an idle-high uart line.
 */
`timescale 1ns/1ps
module bleec_host_model (
    input wire logic i_core_clk, // core clock
    input wire logic i_scl_oe, // device pulls scl
    input wire logic i_sda_oe, // device pulls sda
    output logic o_entry, // entry pin
    output logic o_rst_n, // reset pin
    output logic o_rx, // uart line to device
    output logic o_scl, // resolved scl
    output logic o_sda // resolved sda
);
    logic entry_q = 1'h0;
    logic rst_n_q = 1'h1;
    logic rx_q = 1'h1;
    logic sda_q = 1'h1;
    assign o_entry = entry_q;
    assign o_rst_n = rst_n_q;
    assign o_rx = rx_q;
    // pull-up wins unless someone drives low
    assign o_scl = !i_scl_oe;
    assign o_sda = !i_sda_oe && sda_q;
    // entry level is held until the bench releases it after the boot check
    task automatic force_boot(input logic lvl);
        @(posedge i_core_clk);
        entry_q <= lvl;
        repeat (2) @(posedge i_core_clk);
        rst_n_q <= 1'h0;
        repeat (4) @(posedge i_core_clk);
        rst_n_q <= 1'h1;
    endtask
endmodule

// >>> tb/test_boot_loader_entry_control.sv
/*
 * Testbench for bleec_top: boot paths, password gate, link routing.
 * Assumes the host model and the bound checker are compiled with it.
 */
`timescale 1ns/1ps
module test_boot_loader_entry_control;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic sel = 1'h0;
    logic tx = 1'h1;
    logic sda_low = 1'h0;
    logic scl_low = 1'h0;
    logic [31:0] vec = 32'h0000_1000;
    logic [31:0] sp = 32'h2000_0000;
    logic [31:0] rdv;
    logic entry, rst_n, rx, scl, sda, scl_oe, sda_oe, saw_pulse;
    logic [31:0] rdata;
    logic lrun, arun, acc, bpulse, utx, lrx, lscl, lsda;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    always #4 clk = ~clk;
    bleec_top dut (.i_core_clk(clk), .i_rst(rst), .i_loader_entry_pin(entry),
        .i_external_reset_pin_n(rst_n), .i_reset_vector(vec), .i_stack_pointer(sp), .i_sel_i2c(sel),
        .i_loader_uart_rx(rx), .i_loader_i2c_clock(scl), .i_loader_i2c_data(sda), .i_link_tx(tx),
        .i_link_sda_low(sda_low), .i_link_scl_low(scl_low), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .o_loader_run(lrun), .o_app_run(arun), .o_access_ok(acc),
        .o_boot_reset(bpulse), .o_loader_uart_tx(utx), .o_loader_i2c_clock_oe(scl_oe),
        .o_loader_i2c_data_oe(sda_oe), .o_loader_i2c_clock_o(), .o_loader_i2c_data_o(),
        .o_link_rx(lrx), .o_link_scl(lscl), .o_link_sda(lsda));
    bleec_host_model host (.i_core_clk(clk), .i_scl_oe(scl_oe), .i_sda_oe(sda_oe), .o_entry(entry),
        .o_rst_n(rst_n), .o_rx(rx), .o_scl(scl), .o_sda(sda));
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (bpulse === 1'h1) saw_pulse <= 1'h1;
        if (cycles == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 rdv = rdata;
    endtask
    // waits out the reboot; 20 cycles is well inside the settle time
    task automatic boot_done();
        int n;
        repeat (20) @(posedge clk);
        for (n = 0; n < 300 && lrun !== 1'h1 && arun !== 1'h1; n++) @(posedge clk);
        rd_reg(bleec_pkg::REG_STATUS);
        host.entry_q <= 1'h0;
    endtask
    // all words all ones except word 0, last write triggers the compare
    task automatic send_pwd(input logic [31:0] w0);
        int i;
        for (i = 0; i < 8; i++) wr_reg(bleec_pkg::REG_PWD + 8'(4 * i), i == 0 ? w0 : 32'hFFFF_FFFF);
        repeat (3) @(posedge clk);
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        saw_pulse = 1'h0;
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        rd_reg(bleec_pkg::REG_CFG);
        check(rdv, 32'h5);
        boot_done();
        check({lrun, arun, rdv[9:7]}, {2'h1, bleec_pkg::CAUSE_NONE});
        wr_reg(bleec_pkg::REG_CMD, bleec_pkg::CMD_LOADER_ENTRY);
        boot_done();
        check({lrun, arun, rdv[9:7]}, {2'h2, bleec_pkg::CAUSE_SWREQ});
        send_pwd(32'h0);
        check(acc, 1'h0);
        send_pwd(32'hFFFF_FFFF);
        check(acc, 1'h1);
        rd_reg(bleec_pkg::REG_PWD);
        check(rdv, 32'h0);
        rd_reg(bleec_pkg::REG_STATUS);
        check(rdv[6:0], 7'h30);
        tx <= 1'h0;
        host.rx_q <= 1'h0;
        repeat (5) @(posedge clk);
        check({utx, lrx, lscl, lsda}, 32'h3);
        sel <= 1'h1;
        sda_low <= 1'h1;
        scl_low <= 1'h1;
        repeat (5) @(posedge clk);
        check({sda_oe, sda}, 32'h2);
        check({sda_oe, sda, scl_oe, scl, lscl, lsda}, 32'h28);
        {sel, sda_low, scl_low, tx, host.rx_q} <= 5'h3;
        saw_pulse = 1'h0;
        host.force_boot(1'h1);
        boot_done();
        check({saw_pulse, lrun, arun, rdv[9:7]}, {3'h6, bleec_pkg::CAUSE_PIN});
        wr_reg(bleec_pkg::REG_CMD, bleec_pkg::CMD_APP_RESET);
        boot_done();
        check({lrun, arun}, 32'h1);
        wr_reg(bleec_pkg::REG_CFG, 32'h7);
        host.force_boot(1'h1);
        boot_done();
        check({lrun, arun}, 32'h1);
        {vec, sp} <= {64{1'h1}};
        host.force_boot(1'h0);
        boot_done();
        check({lrun, arun, rdv[9:7]}, {2'h2, bleec_pkg::CAUSE_BLANK});
        {vec, sp} <= 64'h0000_1000_2000_0000;
        wr_reg(bleec_pkg::REG_CMD, bleec_pkg::CMD_APP_RESET);
        boot_done();
        wr_reg(bleec_pkg::REG_CFG, 32'h1);
        host.force_boot(1'h0);
        boot_done();
        check({lrun, arun}, 32'h2);
        send_pwd(32'hFFFF_FFFF);
        wr_reg(bleec_pkg::REG_CFG, 32'h4);
        {vec, sp} <= {64{1'h1}};
        host.force_boot(1'h1);
        boot_done();
        check({lrun, arun, rdv[9:7]}, {2'h1, bleec_pkg::CAUSE_DISABLED});
        wr_reg(bleec_pkg::REG_CMD, bleec_pkg::CMD_LOADER_ENTRY);
        boot_done();
        check({lrun, arun}, 32'h1);
        report_and_stop();
    end
endmodule
